// file: design/apd_pkg.sv
package apd_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFF_GAIN     = 8'h0C;
    localparam logic [7:0] OFF_PNEXT    = 8'h10;
    localparam logic [7:0] OFF_PCUR     = 8'h14;
    localparam logic [7:0] OFF_RNEXT    = 8'h18;
    localparam logic [7:0] OFF_RCUR     = 8'h1C;
    localparam logic [7:0] OFF_STATUS   = 8'h20;
    localparam logic [7:0] OFF_CLIP     = 8'h24;
    localparam logic [7:0] OFF_PIO      = 8'h28;
    localparam logic [7:0] OFF_FORMAT   = 8'h2C;
    // ==========================================================
    // status bit positions
    localparam int ST_IRQ_ALLOW  = 31;
    localparam int ST_P_REQ      = 9;
    localparam int ST_P_ACT      = 8;
    localparam int ST_R_REQ      = 1;
    localparam int ST_R_ACT      = 0;
    // ==========================================================
    // gain register fields
    localparam int GN_PHONES     = 27;
    localparam int GN_LINEOUT    = 26;
    localparam int GN_SPEAKER    = 25;
    localparam int GN_INSEL      = 24;
    localparam int GN_MON_LSB    = 20;
    localparam int GN_GIL_LSB    = 16;
    localparam int GN_GIR_LSB    = 12;
    localparam int GN_AOL_LSB    = 6;
    localparam int GN_AOR_LSB    = 0;
    // ==========================================================
    // paging and formats
    localparam logic [31:0] PAGE_MASK  = 32'hFFFF_F000;
    localparam logic [11:0] PAGE_LAST  = 12'hFFC;
    localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
    localparam logic [3:0]  PIO_RESET  = 4'hF;
    localparam logic [1:0]  FMT_LIN16  = 2'h0;
    localparam logic [1:0]  FMT_MULAW  = 2'h1;
    localparam logic [1:0]  FMT_ALAW   = 2'h2;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage

// file: design/apd_top.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
// Contract
// - current pointers return coherently in one full 32-bit read
// - status bit 9 playback request set on need, cleared by write, resets 1
// - status bit 1 record request set on need, cleared by write, resets 1
// - status bit 8 playback active set on start, cleared on finish
// - status bit 0 record active set on start, cleared on finish
// - irq while irq_allow and both requests set; status at 0x020
// - playback request may lead record; irq repeats when record asserts
// - word aligned data only, samples two's complement
// - 8-bit mono: four bytes, earliest in bits 31..24
// - 8-bit stereo: left over right, earlier pair upper halfword
// - 16-bit mono: two halfwords, earlier upper
// - 16-bit stereo: left upper halfword, right lower
// - gain bits 27..24 drive phones, lineout, speaker, input select
// - input select 0 line, 1 microphone, never both
// - monitor attenuation bits 23..20, 6 dB per step
// - input gain fields bits 19..16 and 15..12, 1.5 dB steps
// - output attenuation bits 11..6 and 5..0, 1.5 dB steps
// - clip flag sticky, write 0 clears, clear wins over set
// - page end moves next into current and raises request
// - playback then record next write starts both channels
// - current pointer only increments as data moves
// - format 0 linear16, 1 mu-law, 2 A-law; stereo separate bit
module apd_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      play_addr,
    output logic             play_req,
    input  wire logic        play_ack,
    input  wire logic [31:0] play_word,
    output logic [15:0]      play_left,
    output logic [15:0]      play_right,
    output logic             play_strobe,
    input  wire logic        sample_tick,
    input  wire logic [15:0] rec_left,
    input  wire logic [15:0] rec_right,
    output logic [31:0]      rec_addr,
    output logic [31:0]      rec_word,
    output logic             rec_req,
    input  wire logic        rec_ack,
    input  wire logic        clip_event,
    output logic             irq,
    output logic             phones_on,
    output logic             lineout_on,
    output logic             speaker_on,
    output logic             input_source_select,
    output logic [3:0]       monitor_attenuation,
    output logic [3:0]       gain_in_left,
    output logic [3:0]       gain_in_right,
    output logic [5:0]       atten_out_left,
    output logic [5:0]       atten_out_right,
    output logic [1:0]       sample_format_select,
    output logic             stereo_select,
    output logic [1:0]       pio_out,
    input  wire logic [1:0]  pio_in
);
    // ==========================================================
    // state
    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic        bvalid;
        logic        bslv;
        logic        rvalid;
        logic [31:0] rdata;
        logic        rslv;
        logic [31:0] gain;
        logic [31:0] p_next;
        logic [31:0] p_cur;
        logic [31:0] r_next;
        logic [31:0] r_cur;
        logic        irq_allow;
        logic        p_areq;
        logic        r_areq;
        logic        p_act;
        logic        r_act;
        logic        clip;
        logic [1:0]  codec_parallel_lines;
        logic [1:0]  fmt;
        logic        stereo;
        logic [1:0]  slot;
        logic [31:0] p_word;
        logic        p_have;
        logic        p_pend;
        logic [31:0] r_word;
        logic        r_full;
        logic [15:0] pl;
        logic [15:0] pr;
        logic        pstb;
        logic        irq;
    } apd_state_s;

    apd_state_s st_reg;
    apd_state_s st_next;

    logic        wr_go;
    logic [31:0] wmask;
    logic [1:0]  slots;
    logic [31:0] rd_val;
    logic        rd_hit;
    logic        wr_hit;

    // ==========================================================
    // bus handshakes
    assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bslv ? apd_pkg::RESP_SLV : apd_pkg::RESP_OKAY;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rslv ? apd_pkg::RESP_SLV : apd_pkg::RESP_OKAY;

    // codec control fields
    assign phones_on            = st_reg.gain[apd_pkg::GN_PHONES];
    assign lineout_on           = st_reg.gain[apd_pkg::GN_LINEOUT];
    assign speaker_on           = st_reg.gain[apd_pkg::GN_SPEAKER];
    assign input_source_select  = st_reg.gain[apd_pkg::GN_INSEL];
    assign monitor_attenuation  = st_reg.gain[apd_pkg::GN_MON_LSB +: 4];
    assign gain_in_left         = st_reg.gain[apd_pkg::GN_GIL_LSB +: 4];
    assign gain_in_right        = st_reg.gain[apd_pkg::GN_GIR_LSB +: 4];
    assign atten_out_left       = st_reg.gain[apd_pkg::GN_AOL_LSB +: 6];
    assign atten_out_right      = st_reg.gain[apd_pkg::GN_AOR_LSB +: 6];
    assign sample_format_select = st_reg.fmt;
    assign stereo_select        = st_reg.stereo;
    assign pio_out              = st_reg.codec_parallel_lines;

    // dma ports
    assign play_addr   = st_reg.p_cur;
    assign play_req    = st_reg.p_act && st_reg.p_pend;
    assign rec_addr    = st_reg.r_cur;
    assign rec_word    = st_reg.r_word;
    assign rec_req     = st_reg.r_act && st_reg.r_full;
    assign play_left   = st_reg.pl;
    assign play_right  = st_reg.pr;
    assign play_strobe = st_reg.pstb;
    assign irq         = st_reg.irq;

    // samples per word: 16-bit stereo 1, 8-bit mono 4, others 2
    always_comb begin
        if (st_reg.fmt == apd_pkg::FMT_LIN16) begin
            slots = st_reg.stereo ? 2'h0 : 2'h1;
        end else begin
            slots = st_reg.stereo ? 2'h1 : 2'h3;
        end
    end

    // byte strobe expansion and read mux
    always_comb begin
        wmask  = 32'h0000_0000;
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            apd_pkg::OFF_GAIN:   rd_val = st_reg.gain;
            apd_pkg::OFF_PNEXT:  rd_val = st_reg.p_next;
            apd_pkg::OFF_PCUR:   rd_val = st_reg.p_cur;
            apd_pkg::OFF_RNEXT:  rd_val = st_reg.r_next;
            apd_pkg::OFF_RCUR:   rd_val = st_reg.r_cur;
            apd_pkg::OFF_STATUS: begin
                rd_val[apd_pkg::ST_IRQ_ALLOW] = st_reg.irq_allow;
                rd_val[apd_pkg::ST_P_REQ]     = st_reg.p_areq;
                rd_val[apd_pkg::ST_P_ACT]     = st_reg.p_act;
                rd_val[apd_pkg::ST_R_REQ]     = st_reg.r_areq;
                rd_val[apd_pkg::ST_R_ACT]     = st_reg.r_act;
            end
            apd_pkg::OFF_CLIP:   rd_val[0] = st_reg.clip;
            apd_pkg::OFF_PIO:    rd_val = {28'h0000000, pio_in, st_reg.codec_parallel_lines};
            apd_pkg::OFF_FORMAT: rd_val = {29'h00000000, st_reg.stereo, st_reg.fmt};
            default:             rd_hit = 1'b0;
        endcase
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{s_axi_wstrb[i] | st_reg.w_got}};
        end
    end

    // ==========================================================
    // next-state logic
    always_comb begin
        st_next      = st_reg;
        st_next.pstb = 1'b0;
        wr_go        = 1'b0;
        wr_hit       = 1'b1;
        // write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_got  = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_got  = 1'b1;
            st_next.w_data = (s_axi_wdata & wmask) | (st_reg.w_data & ~wmask);
        end
        if (st_reg.aw_got && st_reg.w_got) begin
            wr_go          = 1'b1;
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_val;
            st_next.rslv   = !rd_hit;
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // playback fetch and unpack, two's complement passed through
        if (play_req && play_ack) begin
            st_next.p_word = play_word;
            st_next.p_have = 1'b1;
            st_next.p_pend = 1'b0;
            st_next.slot   = 2'h0;
            st_next.p_cur  = st_reg.p_cur + apd_pkg::WORD_STEP;
        end
        if (sample_tick && st_reg.p_have) begin
            st_next.pstb = 1'b1;
            if (st_reg.fmt == apd_pkg::FMT_LIN16 && st_reg.stereo) begin
                st_next.pl = st_reg.p_word[31:16];
                st_next.pr = st_reg.p_word[15:0];
            end else if (st_reg.fmt == apd_pkg::FMT_LIN16) begin
                st_next.pl = st_reg.p_word[31 - 16*st_reg.slot[0] -: 16];
                st_next.pr = st_next.pl;
            end else if (st_reg.stereo) begin
                st_next.pl = {8'h00, st_reg.p_word[31 - 16*st_reg.slot[0] -: 8]};
                st_next.pr = {8'h00, st_reg.p_word[23 - 16*st_reg.slot[0] -: 8]};
            end else begin
                st_next.pl = {8'h00, st_reg.p_word[31 - 8*st_reg.slot -: 8]};
                st_next.pr = st_next.pl;
            end
            // record packs into the same slot layout
            if (st_reg.fmt == apd_pkg::FMT_LIN16 && st_reg.stereo) begin
                st_next.r_word = {rec_left, rec_right};
            end else if (st_reg.fmt == apd_pkg::FMT_LIN16) begin
                st_next.r_word[31 - 16*st_reg.slot[0] -: 16] = rec_left;
            end else if (st_reg.stereo) begin
                st_next.r_word[31 - 16*st_reg.slot[0] -: 16] = {rec_left[7:0], rec_right[7:0]};
            end else begin
                st_next.r_word[31 - 8*st_reg.slot -: 8] = rec_left[7:0];
            end
            if (st_reg.slot == slots) begin
                st_next.slot   = 2'h0;
                st_next.p_have = 1'b0;
                st_next.p_pend = 1'b1;
                st_next.r_full = 1'b1;
            end else begin
                st_next.slot = st_reg.slot + 2'h1;
            end
        end
        if (rec_req && rec_ack) begin
            st_next.r_full = 1'b0;
            st_next.r_cur  = st_reg.r_cur + apd_pkg::WORD_STEP;
        end

        // page chaining: wrap onto next page or stop
        if (play_req && play_ack && st_reg.p_cur[11:0] == apd_pkg::PAGE_LAST) begin
            if (!st_reg.p_areq) begin
                st_next.p_cur  = st_reg.p_next;
                st_next.p_areq = 1'b1;
            end else begin
                st_next.p_act = 1'b0;
            end
        end
        if (rec_req && rec_ack && st_reg.r_cur[11:0] == apd_pkg::PAGE_LAST) begin
            if (!st_reg.r_areq) begin
                st_next.r_cur  = st_reg.r_next;
                st_next.r_areq = 1'b1;
            end else begin
                st_next.r_act = 1'b0;
            end
        end

        // clip flag: hardware set
        if (clip_event) begin
            st_next.clip = 1'b1;
        end

        // register writes
        if (wr_go) begin
            case (st_reg.aw_addr)
                apd_pkg::OFF_GAIN:  st_next.gain = st_reg.w_data;
                apd_pkg::OFF_PNEXT: begin
                    st_next.p_next = st_reg.w_data & apd_pkg::PAGE_MASK;
                    st_next.p_areq = 1'b0;
                    if (!st_reg.p_act) begin
                        st_next.p_cur  = st_reg.w_data & apd_pkg::PAGE_MASK;
                        st_next.p_areq = 1'b1;
                    end
                end
                apd_pkg::OFF_PCUR:  st_next.p_cur = st_reg.w_data;
                apd_pkg::OFF_RNEXT: begin
                    st_next.r_next = st_reg.w_data & apd_pkg::PAGE_MASK;
                    st_next.r_areq = 1'b0;
                    if (!st_reg.r_act) begin
                        st_next.r_cur  = st_reg.w_data & apd_pkg::PAGE_MASK;
                        st_next.r_areq = 1'b1;
                        st_next.p_act  = 1'b1;
                        st_next.r_act  = 1'b1;
                        st_next.p_pend = 1'b1;
                        st_next.p_have = 1'b0;
                        st_next.r_full = 1'b0;
                        st_next.slot   = 2'h0;
                    end
                end
                apd_pkg::OFF_RCUR:   st_next.r_cur = st_reg.w_data;
                apd_pkg::OFF_STATUS: st_next.irq_allow = st_reg.w_data[apd_pkg::ST_IRQ_ALLOW];
                apd_pkg::OFF_CLIP: begin
                    if (!st_reg.w_data[0]) begin
                        st_next.clip = 1'b0;
                    end
                end
                apd_pkg::OFF_PIO:    st_next.codec_parallel_lines = st_reg.w_data[1:0];
                apd_pkg::OFF_FORMAT: begin
                    st_next.fmt    = st_reg.w_data[1:0];
                    st_next.stereo = st_reg.w_data[2];
                end
                default: wr_hit = 1'b0;
            endcase
            st_next.bslv = !wr_hit;
        end
        // level interrupt, high while irq_allow and both requests are set
        st_next.irq = st_next.irq_allow && st_next.p_areq && st_next.r_areq;
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg        <= '0;
            st_reg.p_areq <= 1'b1;
            st_reg.r_areq <= 1'b1;
            st_reg.codec_parallel_lines    <= apd_pkg::PIO_RESET[1:0];
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // checks
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == (st_reg.irq_allow && st_reg.p_areq && st_reg.r_areq))
        else $error("irq does not follow enable and both requests");
    clip_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && st_reg.aw_addr == apd_pkg::OFF_CLIP && !st_reg.w_data[0]) |=> !st_reg.clip)
        else $error("clip flag survived a clear");
    clip_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clip_event |=> st_reg.clip || $past(wr_go && st_reg.aw_addr == apd_pkg::OFF_CLIP))
        else $error("clip event lost");
    page_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.p_next[11:0] == 12'h000 && st_reg.r_next[11:0] == 12'h000)
        else $error("next page low bits not zero");
    pnext_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && st_reg.aw_addr == apd_pkg::OFF_PNEXT && st_reg.p_act) |=> !st_reg.p_areq)
        else $error("playback request not cleared");
    start_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && st_reg.aw_addr == apd_pkg::OFF_RNEXT && !st_reg.r_act) |=> (st_reg.p_act && st_reg.r_act))
        else $error("dma did not start together");
    ptr_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (play_req && play_ack && st_reg.p_cur[11:0] != apd_pkg::PAGE_LAST && !wr_go)
        |=> st_reg.p_cur == $past(st_reg.p_cur) + apd_pkg::WORD_STEP)
        else $error("playback pointer did not step four");
    chain_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rec_req && rec_ack && st_reg.r_cur[11:0] == apd_pkg::PAGE_LAST && !st_reg.r_areq && !wr_go)
        |=> (st_reg.r_areq && st_reg.r_cur == $past(st_reg.r_next)))
        else $error("record page did not chain");
    stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (play_req && play_ack && st_reg.p_cur[11:0] == apd_pkg::PAGE_LAST && st_reg.p_areq && !wr_go)
        |=> !st_reg.p_act)
        else $error("playback did not stop without next page");
endmodule

// file: test/apd_mem_model.sv
`timescale 1ns/1ns
// ==========================================================
// memory model: serves playback words, acknowledges record words without storing them
module apd_mem_model (
    input  wire logic        aclk,
    input  wire logic        play_req,
    input  wire logic [31:0] play_addr,
    output logic             play_ack,
    output logic [31:0]      play_word,
    input  wire logic        rec_req,
    output logic             rec_ack
);
    logic [1:0] pace;
    initial begin
        pace = 2'h0;
        play_ack = 1'b0;
        rec_ack = 1'b0;
        play_word = 32'h0000_0000;
    end
    // alternating prompt and slow answers; idle data toggles
    always @(posedge aclk) begin
        pace <= pace + 2'h1;
        play_ack <= play_req && !play_ack && pace[0]; // whole aligned words
        rec_ack <= rec_req && !rec_ack && pace[1];
        play_word <= (play_req && pace[0]) ? (play_addr ^ 32'h5A5A_0000) : ~play_word;
    end
endmodule

// file: test/apd_top_tb.sv
`timescale 1ns/1ns
module apd_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, play_req, play_ack;
    logic play_strobe, sample_tick, rec_req, rec_ack, clip_event, irq, phones_on, lineout_on;
    logic speaker_on, input_source_select, stereo_select;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, play_addr, play_word, rec_addr, rec_word, got;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, sample_format_select, pio_out;
    logic [3:0]  monitor_attenuation, gain_in_left, gain_in_right;
    logic [5:0]  atten_out_left, atten_out_right;
    logic [15:0] play_left, play_right;
    int          fail_count, checks_done;
    apd_top apd_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .play_addr(play_addr), .play_req(play_req), .play_ack(play_ack),
        .play_word(play_word), .play_left(play_left), .play_right(play_right),
        .play_strobe(play_strobe), .sample_tick(sample_tick), .rec_left(16'h1234),
        .rec_right(16'hABCD), .rec_addr(rec_addr), .rec_word(rec_word), .rec_req(rec_req),
        .rec_ack(rec_ack), .clip_event(clip_event), .irq(irq), .phones_on(phones_on),
        .lineout_on(lineout_on), .speaker_on(speaker_on), .input_source_select(input_source_select),
        .monitor_attenuation(monitor_attenuation), .gain_in_left(gain_in_left),
        .gain_in_right(gain_in_right), .atten_out_left(atten_out_left),
        .atten_out_right(atten_out_right), .sample_format_select(sample_format_select),
        .stereo_select(stereo_select), .pio_out(pio_out), .pio_in(2'h2));
    apd_mem_model apd_mem_model_inst (.aclk(aclk), .play_req(play_req), .play_addr(play_addr),
        .play_ack(play_ack), .play_word(play_word), .rec_req(rec_req), .rec_ack(rec_ack));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ==========================================================
    // verdict and comparison
    task automatic summarize();
        if (fail_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one axi4-lite transfer; each channel moves at the rising edge with valid and ready high
    task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
        logic done;
        int n;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        s_axi_bready <= w;
        s_axi_rready <= !w;
        done = 1'b0;
        n = 0;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            done = w ? s_axi_bvalid : s_axi_rvalid;
            got = s_axi_rdata;
            rsp = w ? s_axi_bresp : s_axi_rresp;
            n++;
            if (n > 100) begin
                fail_count++;
                summarize();
            end
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {sample_tick, clip_event, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
        fail_count = 0;
        checks_done = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        xfer(0, apd_pkg::OFF_STATUS, 32'h0); chk(got, 32'h0000_0202);
        xfer(0, apd_pkg::OFF_CLIP, 32'h0); chk(got, 32'h0);
        xfer(0, apd_pkg::OFF_PIO, 32'h0); chk({got[29:0], pio_out}, 32'h0000_002F);
        for (int i = 0; i < 2; i++) begin
            xfer(1, apd_pkg::OFF_GAIN, i ? 32'h0F0F_FFFF : 32'h0ABC_DEF5);
            chk({4'h0, phones_on, lineout_on, speaker_on, input_source_select, monitor_attenuation,
                 gain_in_left, gain_in_right, atten_out_left, atten_out_right},
                i ? 32'h0F0F_FFFF : 32'h0ABC_DEF5);
        end
        for (int f = 0; f < 6; f++) begin
            xfer(1, apd_pkg::OFF_FORMAT, {29'h0, f[0], 2'(f >> 1)});
            chk({29'h0, stereo_select, sample_format_select}, {29'h0, f[0], 2'(f >> 1)});
        end
        xfer(1, apd_pkg::OFF_STATUS, 32'hFFFF_FFFF);
        xfer(0, apd_pkg::OFF_STATUS, 32'h0); chk(got, 32'h8000_0202);
        chk({31'h0, irq}, 32'h1);
        xfer(1, apd_pkg::OFF_STATUS, 32'h0);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        clip_event <= 1'b1;
        @(posedge aclk);
        clip_event <= 1'b0;
        xfer(0, apd_pkg::OFF_CLIP, 32'h0); chk(got & 32'h1, 32'h1);
        xfer(1, apd_pkg::OFF_CLIP, 32'h0);
        xfer(0, apd_pkg::OFF_CLIP, 32'h0); chk(got, 32'h0);
        xfer(1, apd_pkg::OFF_STATUS, 32'h8000_0000);
        xfer(1, apd_pkg::OFF_PNEXT, 32'h1000_0ABC); // low bits masked to page; current loaded while idle
        xfer(0, apd_pkg::OFF_PNEXT, 32'h0); chk(got, 32'h1000_0000);
        xfer(0, apd_pkg::OFF_PCUR, 32'h0); chk(got, 32'h1000_0000);
        xfer(1, apd_pkg::OFF_RNEXT, 32'h2000_0000);
        xfer(0, apd_pkg::OFF_STATUS, 32'h0); chk(got & 32'h101, 32'h101);
        // eight ticks of steady run, then pointers moved to page ends for chain and stop
        for (int k = 0; k < 10; k++) begin
            if (k == 8) begin
                xfer(0, apd_pkg::OFF_PCUR, 32'h0); chk(got, 32'h1000_0014);
                chk({31'h0, got > 32'h1000_0000}, 32'h1);
                xfer(0, apd_pkg::OFF_RCUR, 32'h0); chk(got, 32'h2000_0010);
                xfer(1, apd_pkg::OFF_RNEXT, 32'h3000_0000); chk({31'h0, irq}, 32'h0);
                xfer(1, apd_pkg::OFF_RCUR, 32'h2000_0FFC);
                xfer(1, apd_pkg::OFF_PCUR, 32'h1000_0FFC);
            end
            sample_tick <= 1'b1;
            @(posedge aclk);
            sample_tick <= 1'b0;
            repeat (20) @(posedge aclk);
        end
        xfer(0, apd_pkg::OFF_STATUS, 32'h0); chk(got, 32'h8000_0203);
        chk({31'h0, irq}, 32'h1);
        xfer(0, apd_pkg::OFF_RCUR, 32'h0); chk(got, 32'h3000_0000);
        chk(rec_word, 32'h34CD_34CD);
        chk({play_left, play_right}, 32'h0000_0010);
        xfer(0, 8'h3C, 32'h0); chk({rsp, got[29:0]}, {apd_pkg::RESP_SLV, 30'h0});
        summarize();
    end
endmodule
